//--- src/pstc_top.sv
// Module power state controller: register file and per-module sequencers
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pstc_top
  import pstc_pkg::*;
#(
  parameter int N_MOD = 32,
  parameter int CPU_IDX = 14
) (
  input wire logic clk,                    // System clock, 10 MHz
  input wire logic rst_b,                  // Asynchronous reset, low active
  input wire logic ce,                     // Clock enable
  input wire logic [11:0] addr,            // Register byte address
  input wire logic [31:0] wdata,           // Write data
  input wire logic wr_en,                  // Write strobe
  input wire logic rd_en,                  // Read strobe
  output logic [31:0] rdata_q,             // Read data, cycle after strobe
  input wire logic [N_MOD-1:0] mod_busy,   // Bus access outstanding per module
  output logic [N_MOD-1:0] mod_clk_en,     // Module clock enables
  output logic [N_MOD-1:0] mod_rst_b,      // Module resets, low asserted
  output logic cpu_local_reset_status_b                  // Processor local reset, low asserted
);

  initial begin
    if (N_MOD < 1 || N_MOD > PSTC_MAX_MOD) $error("N_MOD out of range");
    if (CPU_IDX < 0 || CPU_IDX >= N_MOD) $error("CPU_IDX out of range");
  end

  pstc_ctl_t ctl_q [N_MOD];
  pstc_mod_t mod_s [N_MOD];
  wire logic [N_MOD-1:0] pend_s;
  logic [31:0] stat_word [N_MOD];
  logic [31:0] ctl_word [N_MOD];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic [PSTC_IDX_W-1:0] idx = addr[PSTC_BANK_LSB-1:2];
  wire logic idx_ok = (addr[1:0] == 2'h0) && ({27'h0, idx} < 32'(N_MOD));
  wire logic ctl_hit = idx_ok && (addr[11:PSTC_BANK_LSB] == PSTC_CTL_BASE[11:PSTC_BANK_LSB]);
  wire logic stat_hit = idx_ok && (addr[11:PSTC_BANK_LSB] == PSTC_STAT_BASE[11:PSTC_BANK_LSB]);
  wire logic cmd_hit = addr == PSTC_CMD_ADDR;
  wire logic pend_hit = addr == PSTC_PEND_ADDR;
  // start only on a command write
  wire logic go = ce && wr_en && cmd_hit && wdata[PSTC_GO_BIT];
  wire logic any_pend = |pend_s;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, one per module; writes to reserved bits are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N_MOD; i++) begin
        ctl_q[i] <= '{force_en: 1'b0, next: PSTC_NS_RSTDIS};
      end
    end else if (ce && wr_en && ctl_hit) begin
      ctl_q[idx] <= '{force_en: wdata[PSTC_CTL_FORCE], next: wdata[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One sequencer per module, plus its read words
  for (genvar g = 0; g < N_MOD; g++) begin : g_mod
    pstc_mod_fsm #(
      .IS_CPU(g == CPU_IDX)
    ) u_fsm (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .ctl(ctl_q[g]),
      .go(go),
      .bus_busy(mod_busy[g]),
      .mod(mod_s[g]),
      .pending_q(pend_s[g])
    );
    assign stat_word[g] = {20'h0, 1'b1, mod_s[g].rst_b, mod_s[g].local_reset_status_done, mod_s[g].local_reset_status_b, 2'h0,
                           mod_s[g].code};
    assign ctl_word[g] = {ctl_q[g].force_en, 28'h0, ctl_q[g].next};
  end

  // Module outputs gathered in one process, so each output vector has a single driver
  always_comb begin
    for (int i = 0; i < N_MOD; i++) begin
      mod_clk_en[i] = mod_s[i].clk_en;
      mod_rst_b[i] = mod_s[i].rst_b;
    end
  end

  assign cpu_local_reset_status_b = mod_s[CPU_IDX].local_reset_status_b;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; unmapped addresses read zero
  wire logic [31:0] rd_sel = stat_hit ? stat_word[idx] :
                             ctl_hit ? ctl_word[idx] :
                             pend_hit ? {31'h0, any_pend} : 32'h0;

  // Read data register; holds for the one enabled cycle after the strobe, and stays frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= rd_en ? rd_sel : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic chk_stat_q, chk_ctl_q, chk_pend_q, chk_any_q;
  logic [PSTC_IDX_W-1:0] chk_idx_q;
  logic [N_MOD-1:0] chk_rst_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_stat_q <= 1'b0;
      chk_ctl_q <= 1'b0;
      chk_idx_q <= '0;
      chk_rst_q <= '0;
      chk_pend_q <= 1'b0;
      chk_any_q <= 1'b0;
    end else begin
      chk_stat_q <= ce && rd_en && stat_hit;
      chk_ctl_q <= ce && rd_en && ctl_hit;
      chk_idx_q <= idx;
      chk_rst_q <= mod_rst_b;
      chk_pend_q <= ce && rd_en && pend_hit;
      chk_any_q <= any_pend;
    end
  end

  module_reset_status_bit_a: assert property (chk_stat_q |-> rdata_q[PSTC_ST_MODULE_RESET_STATUS] == chk_rst_q[chk_idx_q])
    else $error("reset status bit wrong");
  stat_rsvd_a: assert property (chk_stat_q |-> rdata_q[31:12] == 20'h0 && rdata_q[PSTC_ST_RSVD1] && rdata_q[7:6] == 2'h0)
    else $error("status reserved bits wrong");
  ctl_rsvd_a: assert property (chk_ctl_q |-> rdata_q[30:3] == 28'h0) else $error("control reserved bits wrong");
  ctl_store_a: assert property (ce && wr_en && ctl_hit ##1 ce && rd_en && addr == $past(addr) |=>
    rdata_q[2:0] == $past(wdata[2:0], 2) && rdata_q[PSTC_CTL_FORCE] == $past(wdata[PSTC_CTL_FORCE], 2))
    else $error("control write not stored");
  cpu_done_a: assert property (chk_stat_q && chk_idx_q == PSTC_IDX_W'(CPU_IDX) && rdata_q[PSTC_ST_LDONE]
    |-> rdata_q[PSTC_ST_LOCAL_RESET_STATUS]) else $error("done before local reset release");

  // Pending word shows whether any sequencer was still moving when the read was taken
  pend_bit_a: assert property (chk_pend_q |-> rdata_q == {31'h0, chk_any_q}) else $error("pending bit wrong");
  // Local reset never stands released while the module reset is asserted
  cpu_local_reset_status_a: assert property (!mod_rst_b[CPU_IDX] |-> !cpu_local_reset_status_b) else $error("local reset out of step");
  // A low clock enable freezes every output, read data included
  ce_freeze_a: assert property (!ce |=> $stable(mod_clk_en) && $stable(mod_rst_b) && $stable(rdata_q))
    else $error("outputs moved while frozen");
  // Read data fall back to zero when an enabled cycle takes no read, so stale words linger only while ce is low
  rd_idle_a: assert property (ce && !rd_en |=> rdata_q == 32'h0) else $error("read data not cleared");

endmodule
`default_nettype wire

//--- src/pstc_pkg.sv
// Shared constants and carrier types for the module power state controller
package pstc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: one aligned word per module in each bank
  localparam logic [11:0] PSTC_STAT_BASE = 12'h800; // Module state status bank
  localparam logic [11:0] PSTC_CTL_BASE = 12'ha00;  // Module state control bank
  localparam logic [11:0] PSTC_CMD_ADDR = 12'h120;  // Domain transition command
  localparam logic [11:0] PSTC_PEND_ADDR = 12'h128; // Domain transition status
  localparam int PSTC_BANK_LSB = 7;                 // Bank select from this bit up
  localparam int PSTC_IDX_W = 5;                    // Module index width
  localparam int PSTC_MAX_MOD = 32;                 // Modules one bank can hold

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PSTC_ST_RSVD1 = 11;  // Reserved status bit that reads one
  localparam int PSTC_ST_MODULE_RESET_STATUS = 10;   // Module reset status
  localparam int PSTC_ST_LDONE = 9;   // Local reset complete
  localparam int PSTC_ST_LOCAL_RESET_STATUS = 8;    // Local reset status
  localparam int PSTC_CTL_FORCE = 31; // Force, skip clock-stop handshakes
  localparam int PSTC_GO_BIT = 0;     // Transition start / pending bit

  ////////////////////////////////////////////////////////////////////////////
  // Module states, next-state codes and status codes
  localparam logic [2:0] PSTC_NS_RSTDIS = 3'h0;  // Reset-disabled
  localparam logic [2:0] PSTC_NS_SYNCRST = 3'h1; // Synchronous reset
  localparam logic [2:0] PSTC_NS_DISABLE = 3'h2; // Clock disabled
  localparam logic [2:0] PSTC_NS_ENABLE = 3'h3;  // Enabled
  localparam logic [5:0] PSTC_CODE_DRAIN = 6'h04; // In transition, draining
  localparam logic [5:0] PSTC_CODE_APPLY = 6'h05; // In transition, applying

  ////////////////////////////////////////////////////////////////////////////
  // Timing: local reset stays asserted this long after module reset release
  localparam int PSTC_CLK_PERIOD_NS = 100;
  localparam int PSTC_LOCAL_RESET_STATUS_TIME_NS = 800;
  localparam int PSTC_LOCAL_RESET_STATUS_CYCLES = (PSTC_LOCAL_RESET_STATUS_TIME_NS + PSTC_CLK_PERIOD_NS - 1) / PSTC_CLK_PERIOD_NS;
  localparam int PSTC_LCNT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic force_en;   // Apply next state directly
    logic [2:0] next; // Desired next state
  } pstc_ctl_t;

  typedef struct packed {
    logic [5:0] code; // Present state or transition code
    logic clk_en;     // Module clock enable
    logic rst_b;      // Module reset, low asserted
    logic local_reset_status_b;     // Local reset, low asserted
    logic local_reset_status_done;  // Local reset sequence finished
  } pstc_mod_t;

endpackage

//--- src/pstc_mod_fsm.sv
// State sequencer for one gated module
`timescale 1ns/1ps
`default_nettype none
module pstc_mod_fsm
  import pstc_pkg::*;
#(
  parameter bit IS_CPU = 1'b0
) (
  input wire logic clk,          // System clock
  input wire logic rst_b,        // Asynchronous reset, low active
  input wire logic ce,           // Clock enable, freezes state when low
  input wire pstc_ctl_t ctl,     // Programmed control fields
  input wire logic go,           // Domain transition start pulse
  input wire logic bus_busy,     // Access to this module outstanding
  output var pstc_mod_t mod,     // Module outputs and status
  output logic pending_q         // Transition in progress
);

  typedef enum logic [2:0] {ST_STABLE = 3'b001, ST_DRAIN = 3'b010, ST_APPLY = 3'b100} pstc_st_t;

  initial begin
    if (PSTC_LOCAL_RESET_STATUS_CYCLES < 1 || PSTC_LOCAL_RESET_STATUS_CYCLES >= (1 << PSTC_LCNT_W)) $error("local reset count out of range");
  end

  pstc_st_t st_q, st_d;
  logic [2:0] tgt_q;
  logic [5:0] code_q;
  logic clk_en_q, rst_q, local_reset_status_q, done_q;
  logic [PSTC_LCNT_W-1:0] lcnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the request
  wire logic tgt_ok = ctl.next <= PSTC_NS_ENABLE;
  wire logic tgt_clk_on = (ctl.next == PSTC_NS_ENABLE) || (ctl.next == PSTC_NS_SYNCRST);
  wire logic changes = code_q != {3'h0, ctl.next};
  wire logic start = go && tgt_ok && changes && (st_q == ST_STABLE);
  wire logic need_drain = clk_en_q && !tgt_clk_on && !ctl.force_en;
  wire logic apply_clk = (tgt_q == PSTC_NS_ENABLE) || (tgt_q == PSTC_NS_SYNCRST);
  wire logic apply_rst = (tgt_q == PSTC_NS_ENABLE) || (tgt_q == PSTC_NS_DISABLE);
  // Module reset as it stands after this edge, so local reset drops on the same edge
  wire logic rst_next = (st_q == ST_APPLY) ? apply_rst : rst_q;

  // Next state of the sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_STABLE: if (start) st_d = need_drain ? ST_DRAIN : ST_APPLY;
      ST_DRAIN: if (!bus_busy || ctl.force_en) st_d = ST_APPLY;
      ST_APPLY: st_d = ST_STABLE;
      default: st_d = ST_STABLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and outputs; control registers live elsewhere, so a clock stop loses nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_STABLE;
      tgt_q <= PSTC_NS_RSTDIS;
      code_q <= {3'h0, PSTC_NS_RSTDIS};
      clk_en_q <= 1'b0;
      rst_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      if (start) tgt_q <= ctl.next;
      if (st_d == ST_DRAIN) code_q <= PSTC_CODE_DRAIN;
      else if (st_d == ST_APPLY) code_q <= PSTC_CODE_APPLY;
      if (st_q == ST_APPLY) begin
        code_q <= {3'h0, tgt_q};
        clk_en_q <= apply_clk;
        rst_q <= apply_rst;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local reset of the processor module trails the module reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      local_reset_status_q <= 1'b0;
      done_q <= 1'b0;
      lcnt_q <= '0;
    end else if (ce) begin
      if (!rst_next) begin
        local_reset_status_q <= 1'b0;
        done_q <= 1'b0;
        lcnt_q <= '0;
      end else if (lcnt_q == PSTC_LCNT_W'(PSTC_LOCAL_RESET_STATUS_CYCLES)) begin
        local_reset_status_q <= 1'b1;
        done_q <= local_reset_status_q;
      end else begin
        lcnt_q <= lcnt_q + 1'b1;
      end
    end
  end

  // Status assembly; other modules report local reset released and done
  assign mod.code = code_q;
  assign mod.clk_en = clk_en_q;
  assign mod.rst_b = rst_q;
  // done reads one off the processor
  assign mod.local_reset_status_b = IS_CPU ? local_reset_status_q : 1'b1;
  assign mod.local_reset_status_done = IS_CPU ? done_q : 1'b1;
  assign pending_q = st_q != ST_STABLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_forced_start;
    ce && start && ctl.force_en;
  endsequence
  sequence s_apply_done;
    ce && st_q == ST_APPLY;
  endsequence

  force_skip_a: assert property (s_forced_start |=> st_q == ST_APPLY) else $error("force did not skip drain");
  drain_hold_a: assert property (st_q == ST_DRAIN && bus_busy && !ctl.force_en |=> clk_en_q == $past(clk_en_q))
    else $error("clock gated while busy");
  settle_code_a: assert property (s_apply_done |=> code_q == {3'h0, $past(tgt_q)} && st_q == ST_STABLE)
    else $error("state did not settle to target");
  trans_code_a: assert property (st_q != ST_STABLE |-> code_q >= PSTC_CODE_DRAIN) else $error("bad transition code");
  disable_hold_a: assert property (st_q == ST_STABLE && code_q == {3'h0, PSTC_NS_DISABLE} |-> rst_q && !clk_en_q)
    else $error("disable state wrong outputs");
  local_reset_status_follow_a: assert property (!mod.rst_b |-> !mod.local_reset_status_b || !IS_CPU) else $error("local reset released early");
  done_other_a: assert property (!IS_CPU |-> mod.local_reset_status_done) else $error("done not one off processor");

endmodule
`default_nettype wire

//--- tb/pstc_periph_model.sv
// Behavioural model of the gated peripheral modules
`timescale 1ns/1ps
`default_nettype none
module pstc_periph_model #(
  parameter int N_MOD = 32,
  parameter int WATCH = 5
) (
  input wire logic clk,                  // System clock
  input wire logic [N_MOD-1:0] clk_en,   // Module clock enables
  input wire logic [N_MOD-1:0] rst_b,    // Module resets, low asserted
  input wire logic [N_MOD-1:0] busy_req, // Bench opens an access
  output logic [N_MOD-1:0] busy,         // Access outstanding
  output logic [7:0] cnt_q               // Inner state of watched module
);
  // outstanding access source
  // An access can only be in flight while the module is clocked and out of reset
  assign busy = busy_req & clk_en & rst_b;

  // Counter stands for module registers: frozen without clock, lost in reset
  always_ff @(posedge clk) begin
    if (!rst_b[WATCH]) begin
      cnt_q <= 8'h00;
    end else if (clk_en[WATCH]) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the module power state controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pstc_pkg::*;
  typedef struct packed {logic [4:0] idx; logic [2:0] nxt; logic frc; logic [11:0] st;} pstc_row_t;
  logic clk, rst_b, ce, wr_en, rd_en;
  logic [11:0] addr;
  logic [31:0] wdata, rdata_q, d;
  logic [31:0] mod_busy, mod_clk_en, mod_rst_b, busy_req;
  logic cpu_local_reset_status_b;
  logic [7:0] cnt_q, saved;
  pstc_row_t r;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  pstc_row_t rows [7] = '{'{5'h03, 3'h3, 1'b0, 12'hf03}, '{5'h03, 3'h2, 1'b0, 12'hf02},
    '{5'h03, 3'h1, 1'b0, 12'hb01}, '{5'h03, 3'h0, 1'b0, 12'hb00}, '{5'h1f, 3'h3, 1'b1, 12'hf03},
    '{5'h1f, 3'h1, 1'b1, 12'hb01}, '{5'h00, 3'h2, 1'b1, 12'hf02}};

  pstc_top #(.N_MOD(32), .CPU_IDX(14)) u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .mod_busy(mod_busy),
    .mod_clk_en(mod_clk_en), .mod_rst_b(mod_rst_b), .cpu_local_reset_status_b(cpu_local_reset_status_b));

  pstc_periph_model #(.N_MOD(32), .WATCH(5)) u_periph (.clk(clk), .clk_en(mod_clk_en),
    .rst_b(mod_rst_b), .busy_req(busy_req), .busy(mod_busy), .cnt_q(cnt_q));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle ceiling, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata_q;
  endtask

  // Write then read back on the very next cycle, no idle between the strobes
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] v, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 q = rdata_q;
  endtask

  // Start a transition and poll pending low, bounded
  task automatic go();
    wr(PSTC_CMD_ADDR, 32'h1);
    poll();
  endtask

  // Poll pending low without starting anything new
  task automatic poll();
    logic [31:0] p;
    int k;
    k = 0;
    do begin
      rd(PSTC_PEND_ADDR, p);
      k++;
    end while (p[0] !== 1'b0 && k < 40);
    check(p, 32'h0);
  endtask

  task automatic set_go(input logic [4:0] i, input logic [31:0] v);
    wr(PSTC_CTL_BASE + {5'h00, i, 2'h0}, v);
    go();
  endtask

  task automatic wait_n(input int c);
    repeat (c) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    busy_req = 32'h0;
    wait_n(8);
    check(mod_clk_en | mod_rst_b, 32'h0);
    check(cpu_local_reset_status_b, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, read-only status, unmapped space
    rd(PSTC_STAT_BASE, d);
    check(d, 32'hb00);
    rd(PSTC_STAT_BASE + 12'h038, d);
    check(d, 32'h800);
    wr(PSTC_STAT_BASE + 12'h004, 32'hffffffff);
    rd(PSTC_STAT_BASE + 12'h004, d);
    check(d, 32'hb00);
    rd(12'h7fc, d);
    check(d, 32'h0);
    // Table of state changes, reserved control bits written high
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      wr_rd(PSTC_CTL_BASE + {5'h00, r.idx, 2'h0}, {r.frc, 28'hfffffff, r.nxt}, d);
      check(d, {r.frc, 28'h0, r.nxt});
      go();
      rd(PSTC_STAT_BASE + {5'h00, r.idx, 2'h0}, d);
      check(d, {20'h0, r.st});
      check(mod_clk_en[r.idx], r.nxt[0]);
      check(mod_rst_b[r.idx], r.st[10]);
    end
    // Clock stop held off by an outstanding access
    // clock stops stay unforced outside the force case
    set_go(5'h05, 32'h3);
    busy_req[5] = 1'b1;
    set_go(5'h06, 32'h3);
    wr(PSTC_CTL_BASE + 12'h014, 32'h2);
    wr(PSTC_CMD_ADDR, 32'h1);
    wait_n(4);
    check(mod_clk_en[5], 1'b1);
    rd(PSTC_STAT_BASE + 12'h014, d);
    check(d, 32'hf04);
    rd(PSTC_PEND_ADDR, d);
    check(d, 32'h1);
    busy_req[5] = 1'b0;
    poll();
    check(mod_clk_en[5], 1'b0);
    saved = cnt_q;
    wait_n(6);
    check(cnt_q, saved);
    set_go(5'h05, 32'h3);
    wait_n(3);
    check(32'(cnt_q > saved), 32'h1);
    // Forced clock stop ignores the busy module
    busy_req[6] = 1'b1;
    set_go(5'h06, 32'h80000002);
    check(mod_clk_en[6], 1'b0);
    busy_req[6] = 1'b0;
    // Clock enable low: a control write is not taken
    @(posedge clk);
    ce <= 1'b0;
    wr(PSTC_CTL_BASE + 12'h018, 32'h3);
    @(posedge clk);
    ce <= 1'b1;
    rd(PSTC_CTL_BASE + 12'h018, d);
    check(d, 32'h80000002);
    // Processor module: local reset follows module reset release
    wr(PSTC_CTL_BASE + 12'h038, 32'h3);
    wr(PSTC_CMD_ADDR, 32'h1);
    n = 0;
    while (mod_rst_b[14] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (cpu_local_reset_status_b !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(n, 8);
    wait_n(2);
    // software waits for local reset done
    rd(PSTC_STAT_BASE + 12'h038, d);
    check(d, 32'hf03);
    // Reset in mid-run drops everything at once, then the controller starts over
    @(posedge clk);
    rst_b <= 1'b0;
    #1 check(mod_clk_en | mod_rst_b, 32'h0);
    check(cpu_local_reset_status_b, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(PSTC_STAT_BASE + 12'h014, d);
    check(d, 32'hb00);
    rd(PSTC_CTL_BASE + 12'h014, d);
    check(d, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
